// ===== include/rsli_pkg.sv
// =====================================================================
// rsli_pkg: constants and carrier types for the reference scaling and
// logic input block.
// assumes a 32-bit AXI4-Lite register bus and one 250 MHz clock.
// =====================================================================
package rsli_pkg;

    // =================================================================
    // register byte offsets
    localparam logic [7:0] OFS_INPUT3_GAIN = 8'h00;
    localparam logic [7:0] OFS_INPUT4_GAIN = 8'h04;
    localparam logic [7:0] OFS_SPEED_REF_GAIN = 8'h08;
    localparam logic [7:0] OFS_AOUT1_GAIN = 8'h0c;
    localparam logic [7:0] OFS_AOUT2_GAIN = 8'h10;
    localparam logic [7:0] OFS_AOUT3_GAIN = 8'h14;
    localparam logic [7:0] OFS_ENC_REF_GAIN = 8'h18;
    localparam logic [7:0] OFS_CONTROL = 8'h1c;
    localparam logic [7:0] OFS_INPUT_STATE = 8'h20;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;

    // =================================================================
    // values after reset and scaling figures
    localparam logic [10:0] GAIN_UNITY = 11'h3e8;
    localparam logic [10:0] GAIN_MAX = 11'h7cf;
    localparam logic [10:0] ENC_GAIN_RESET = 11'h1a3;
    localparam logic signed [10:0] FULL_SCALE = 11'sh3e8;
    localparam logic [15:0] LOOP_LOSS_UA = 16'hdac;
    localparam logic [15:0] OFFSET_4MA_UA = 16'hfa0;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // =================================================================
    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // control word, bits 4..0 of the control register
    typedef struct packed {
        logic normal_logic_disable;
        logic current_range_select_high;
        logic current_range_select_low;
        logic voltage_current_select;
        logic reference_source_select;
    } rsli_ctrl_type;

    // synchronised logic terminals, bits 4..0 of the state register
    typedef struct packed {
        logic run_forward;
        logic run_reverse;
        logic inch_forward;
        logic inch_reverse;
        logic run_permit;
    } rsli_pins_type;

    // sticky events: bit 1 permit lost, bit 0 current loop lost
    typedef struct packed {
        logic permit_lost;
        logic loop_loss;
    } rsli_evt_type;

endpackage

// ===== tb/rsli_field_model.sv
// external switch bank and analog reference sources facing rsli_top.
// assumes its tasks are called right after a rising clk edge.
`timescale 1ns/10ps
module rsli_field_model import rsli_pkg::*; (
    // logic terminals
    output logic run_permit_input,
    output logic inch_reverse_input,
    output logic inch_forward_input,
    output logic run_reverse_input,
    output logic run_forward_input,
    // analog readings and loop current
    output logic signed [10:0] general_input_3,
    output logic signed [10:0] general_input_4,
    output logic signed [10:0] speed_reference_reading,
    output logic signed [15:0] encoder_reference,
    output logic [15:0] reference_current_ua,
    output logic signed [10:0] analog_output1_source,
    output logic signed [10:0] analog_output2_source,
    output logic signed [10:0] analog_output3_source
);
    // ==================================================================
    // switches and sources
    initial begin
        {run_forward_input, run_reverse_input, inch_forward_input} = 3'h0;
        {inch_reverse_input, run_permit_input} = 2'h0;
        set_an(0, 0, 0, 0, 0, 0, 0, 0);
    end
    // with normal logic disabled the switch meaning is the bench's own choice
    task automatic set_pins(input rsli_pins_type p);
        {run_forward_input, run_reverse_input, inch_forward_input} <= p[4:2];
        {inch_reverse_input, run_permit_input} <= p[1:0];
    endtask
    task automatic set_an(input int a3, a4, sp, en, cu, o1, o2, o3);
        general_input_3 <= 11'(a3);
        general_input_4 <= 11'(a4);
        speed_reference_reading <= 11'(sp);
        encoder_reference <= 16'(en);
        reference_current_ua <= 16'(cu);
        analog_output1_source <= 11'(o1);
        analog_output2_source <= 11'(o2);
        analog_output3_source <= 11'(o3);
    endtask
    task automatic set_ua(input int cu);
        reference_current_ua <= 16'(cu);
    endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench for rsli_top over its axi4-lite register port.
// assumes rsli_field_model stands in for the switches and sources.
`timescale 1ns/10ps
module tb_top;
    import rsli_pkg::*;
    logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, ramp_hold_active;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic awready, wready, bvalid, arready, rvalid, loop_loss_trip, drive_stop, ramp_freeze;
    logic irq, inch_reverse_cmd, inch_forward_cmd, run_reverse_cmd, run_forward_cmd;
    logic run_permit_input, inch_reverse_input, inch_forward_input;
    logic run_reverse_input, run_forward_input;
    logic signed [10:0] general_input_3, general_input_4, speed_reference_reading;
    logic signed [10:0] analog_output1_source, analog_output2_source, analog_output3_source;
    logic signed [15:0] encoder_reference;
    logic [15:0] reference_current_ua;
    logic signed [10:0] general_input_3_scaled, general_input_4_scaled, pre_ramp_reference;
    logic signed [10:0] analog_output1, analog_output2, analog_output3;
    int error_cnt, checks_done;
    int exp_rng[4] = '{200, 600, 49, 750};

    rsli_top rsli_top_inst (.clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .general_input_3, .general_input_4, .speed_reference_reading,
        .encoder_reference, .reference_current_ua, .analog_output1_source,
        .analog_output2_source, .analog_output3_source, .run_permit_input,
        .inch_reverse_input, .inch_forward_input, .run_reverse_input, .run_forward_input,
        .ramp_hold_active, .general_input_3_scaled, .general_input_4_scaled,
        .pre_ramp_reference, .analog_output1, .analog_output2, .analog_output3,
        .loop_loss_trip, .drive_stop, .ramp_freeze, .inch_reverse_cmd, .inch_forward_cmd,
        .run_reverse_cmd, .run_forward_cmd, .irq);
    rsli_field_model rsli_field_model_inst (.run_permit_input, .inch_reverse_input,
        .inch_forward_input, .run_reverse_input, .run_forward_input, .general_input_3,
        .general_input_4, .speed_reference_reading, .encoder_reference, .reference_current_ua,
        .analog_output1_source, .analog_output2_source, .analog_output3_source);

    // ==================================================================
    // clock, checks and bus tasks
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // result outputs lag their cause by a fixed one to four cycles
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin do @(posedge clk); while (!awready); awvalid <= 1'b0; end
            begin do @(posedge clk); while (!wready); wvalid <= 1'b0; end
        join
        do @(posedge clk); while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("wrong value at %0t: watchdog expired", $time);
        close_out;
    end

    // ==================================================================
    // test sequence
    initial begin
        {rstn, awvalid, wvalid, bready, arvalid, rready, ramp_hold_active} = 7'h0;
        {awaddr, araddr, wdata, wstrb} = '0;
        wstrb = 4'hf;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rdr(8'(4 * i), rd);
            chk(rd, (i == 6) ? 32'h1a3 : 32'h3e8);
        end
        rdr(OFS_CONTROL, rd);
        chk(rd, 32'h0);
        rdr(OFS_IRQ_STATUS, rd);
        chk(rd, 32'h0);
        $display("test reset values done");
        rsli_field_model_inst.set_an(500, -800, 400, 1000, 5000, 500, -600, 250);
        wr(OFS_INPUT3_GAIN, 1999);
        wr(OFS_INPUT4_GAIN, 1999);
        wr(OFS_AOUT1_GAIN, 1999);
        wr(OFS_AOUT2_GAIN, 3000);
        wr(OFS_AOUT3_GAIN, 0);
        settle(2);
        chk(general_input_3_scaled, 999);
        chk(general_input_4_scaled, -1000);
        chk(analog_output1, 999);
        chk(analog_output2, -1000);
        chk(analog_output3, 0);
        rdr(OFS_AOUT2_GAIN, rd);
        chk(rd, 32'h7cf);
        wr(OFS_INPUT4_GAIN, 0);
        settle(2);
        chk(general_input_4_scaled, 0);
        wr(OFS_INPUT4_GAIN, 1000);
        rsli_field_model_inst.set_an(-250, 1000, 400, 1000, 5000, -500, 250, 100);
        wstrb <= 4'he;
        wr(OFS_INPUT3_GAIN, 7);
        wstrb <= 4'hf;
        chk(resp, RESP_OKAY);
        settle(2);
        chk(general_input_3_scaled, -499);
        chk(general_input_4_scaled, 1000);
        chk(analog_output1, -999);
        chk(analog_output2, 499);
        chk(analog_output3, 0);
        $display("test scaling done");
        rsli_field_model_inst.set_pins(5'h01);
        wr(OFS_SPEED_REF_GAIN, 800);
        settle(4);
        chk(pre_ramp_reference, 320);
        rsli_field_model_inst.set_an(-250, 1000, -600, -2000, 5000, -500, 250, 100);
        settle(2);
        chk(pre_ramp_reference, -480);
        wr(OFS_CONTROL, 32'h1);
        settle(2);
        chk(pre_ramp_reference, -838);
        for (int r = 0; r < 4; r++) begin
            wr(OFS_CONTROL, 32'(2 | (r << 2)));
            settle(2);
            chk(pre_ramp_reference, exp_rng[r]);
        end
        wr(OFS_IRQ_MASK, 32'h1);
        rsli_field_model_inst.set_ua(3500);
        settle(2);
        chk(loop_loss_trip, 0);
        rsli_field_model_inst.set_ua(3499);
        settle(3);
        chk(loop_loss_trip, 1);
        chk(irq, 1);
        rsli_field_model_inst.set_ua(3000);
        wr(OFS_CONTROL, 32'h2);
        wr(OFS_IRQ_STATUS, 32'h1);
        settle(2);
        chk(loop_loss_trip, 0);
        chk(irq, 0);
        $display("test reference path done");
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_IRQ_MASK, 32'h2);
        rsli_field_model_inst.set_pins(5'h00);
        settle(4);
        chk(pre_ramp_reference, 0);
        chk({drive_stop, ramp_freeze, irq}, 3'b101);
        rdr(OFS_INPUT_STATE, rd);
        chk(rd[0], 0);
        ramp_hold_active <= 1'b1;
        settle(2);
        chk({drive_stop, ramp_freeze}, 2'b01);
        ramp_hold_active <= 1'b0;
        wr(OFS_IRQ_STATUS, 32'h3);
        settle(2);
        chk(irq, 0);
        $display("test permit done");
        rsli_field_model_inst.set_pins(5'h1f);
        settle(4);
        rdr(OFS_INPUT_STATE, rd);
        chk(rd[4:0], 5'h1f);
        chk({inch_reverse_cmd, inch_forward_cmd, run_reverse_cmd, run_forward_cmd}, 4'hf);
        rsli_field_model_inst.set_pins(5'h01);
        settle(4);
        chk({inch_reverse_cmd, inch_forward_cmd, run_reverse_cmd, run_forward_cmd}, 4'h3);
        rdr(OFS_INPUT_STATE, rd);
        chk(rd[4:0], 5'h01);
        rsli_field_model_inst.set_pins(5'h00);
        settle(4);
        chk({run_reverse_cmd, run_forward_cmd}, 2'b00);
        wr(OFS_CONTROL, 32'h10);
        rsli_field_model_inst.set_pins(5'h1f);
        settle(4);
        chk({inch_reverse_cmd, inch_forward_cmd, run_reverse_cmd, run_forward_cmd}, 4'h0);
        $display("test logic inputs done");
        rdr(8'h40, rd);
        chk(rd, 32'h0);
        chk(resp, RESP_SLVERR);
        wr(OFS_INPUT_STATE, 32'h0);
        chk(resp, RESP_SLVERR);
        $display("test bus errors done");
        close_out;
    end
endmodule

// ===== verilog/rsli_top.sv
// reference scaling and logic input conditioning for a motor drive.
// assumes analog readings and the reference current arrive already
// sampled on clk; the five logic terminals are asynchronous pins.
`timescale 1ns/10ps

module rsli_top import rsli_pkg::*; #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // axi4-lite write
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // analog readings, +/-1000 full scale, and loop current in uA
    input wire logic signed [10:0] general_input_3,
    input wire logic signed [10:0] general_input_4,
    input wire logic signed [10:0] speed_reference_reading,
    input wire logic signed [15:0] encoder_reference,
    input wire logic [15:0] reference_current_ua,
    input wire logic signed [10:0] analog_output1_source,
    input wire logic signed [10:0] analog_output2_source,
    input wire logic signed [10:0] analog_output3_source,
    // logic terminals and ramp hold
    input wire logic run_permit_input,
    input wire logic inch_reverse_input,
    input wire logic inch_forward_input,
    input wire logic run_reverse_input,
    input wire logic run_forward_input,
    input wire logic ramp_hold_active,
    // conditioned results
    output logic signed [10:0] general_input_3_scaled,
    output logic signed [10:0] general_input_4_scaled,
    output logic signed [10:0] pre_ramp_reference,
    output logic signed [10:0] analog_output1,
    output logic signed [10:0] analog_output2,
    output logic signed [10:0] analog_output3,
    output logic loop_loss_trip,
    output logic drive_stop,
    output logic ramp_freeze,
    output logic inch_reverse_cmd,
    output logic inch_forward_cmd,
    output logic run_reverse_cmd,
    output logic run_forward_cmd,
    output logic irq
);

    // =================================================================
    // helpers
    function automatic logic signed [10:0] scale_sat(input logic signed [15:0] x,
                                                     input logic [10:0] g);
        logic signed [27:0] xe;
        logic signed [27:0] ge;
        logic signed [27:0] q;
        xe = 28'(x);
        ge = 28'($signed({1'b0, g}));
        q = (xe * ge) / 28'sd1000;
        if (q > 28'(FULL_SCALE)) begin
            q = 28'(FULL_SCALE);
        end else if (q < -28'(FULL_SCALE)) begin
            q = -28'(FULL_SCALE);
        end
        return 11'(q);
    endfunction

    // current loop to 0..1000 reference; 4 mA ranges span 16 mA
    function automatic logic signed [10:0] loop_to_ref(input logic [15:0] ua,
                                                       input logic [1:0] rng);
        logic [15:0] c;
        logic [15:0] v;
        c = (rng[1] && ua > OFFSET_4MA_UA) ? 16'(ua - OFFSET_4MA_UA) :
            (rng[1] ? 16'h0 : ua);
        v = rng[1] ? 16'(c / 16'd16) : 16'(c / 16'd20);
        if (v > 16'(FULL_SCALE)) begin
            v = 16'(FULL_SCALE);
        end
        if (rng[0]) begin
            v = 16'(16'(FULL_SCALE) - v);
        end
        return 11'(v);
    endfunction

    function automatic logic [10:0] clip_gain(input logic [31:0] w);
        return (w[31:11] != 21'h0 || w[10:0] > GAIN_MAX) ? GAIN_MAX : w[10:0];
    endfunction

    // =================================================================
    // pin synchronisers
    rsli_pins_type pins_meta_q;
    rsli_pins_type pins_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pins_meta_q <= '0;
            pins_q <= '0;
        end else begin
            pins_meta_q <= {run_forward_input, run_reverse_input, inch_forward_input,
                            inch_reverse_input, run_permit_input};
            pins_q <= pins_meta_q;
        end
    end

    // =================================================================
    // registers
    logic [10:0] in3_gain_q, in4_gain_q, spd_gain_q, ao1_gain_q, ao2_gain_q, ao3_gain_q;
    logic [10:0] enc_gain_q;
    rsli_ctrl_type ctrl_q;
    rsli_evt_type irq_status_q, irq_mask_q, evt;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic aw_full_q, w_full_q;
    logic w_lane0_q;
    logic do_write;
    logic [7:0] waddr;

    assign do_write = aw_full_q && w_full_q && !bvalid;
    assign waddr = 8'(aw_addr_q);

    // address and data may arrive in either order; one write at a time
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            awready <= 1'b0;
            wready <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_lane0_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_full_q <= 1'b1;
                aw_addr_q <= awaddr;
            end else if (!aw_full_q && !bvalid) begin
                awready <= 1'b1;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_full_q <= 1'b1;
                w_data_q <= wdata;
                w_lane0_q <= wstrb[0];
            end else if (!w_full_q && !bvalid) begin
                wready <= 1'b1;
            end
            if (do_write) begin
                bvalid <= 1'b1;
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bresp <= (waddr > OFS_IRQ_MASK || waddr[1:0] != 2'h0 ||
                          waddr == OFS_INPUT_STATE) ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // byte lanes: only the low byte lane strobe is checked, so a write without
    // lane 0 changes nothing and the upper lanes are taken whatever their strobes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            in3_gain_q <= GAIN_UNITY;
            in4_gain_q <= GAIN_UNITY;
            spd_gain_q <= GAIN_UNITY;
            ao1_gain_q <= GAIN_UNITY;
            ao2_gain_q <= GAIN_UNITY;
            ao3_gain_q <= GAIN_UNITY;
            enc_gain_q <= ENC_GAIN_RESET;
            ctrl_q <= '0;
            irq_mask_q <= IRQ_RESET;
        end else if (do_write && w_lane0_q) begin
            unique case (waddr)
                OFS_INPUT3_GAIN: in3_gain_q <= clip_gain(w_data_q);
                OFS_INPUT4_GAIN: in4_gain_q <= clip_gain(w_data_q);
                OFS_SPEED_REF_GAIN: spd_gain_q <= clip_gain(w_data_q);
                OFS_AOUT1_GAIN: ao1_gain_q <= clip_gain(w_data_q);
                OFS_AOUT2_GAIN: ao2_gain_q <= clip_gain(w_data_q);
                OFS_AOUT3_GAIN: ao3_gain_q <= clip_gain(w_data_q);
                OFS_ENC_REF_GAIN: enc_gain_q <= clip_gain(w_data_q);
                OFS_CONTROL: ctrl_q <= rsli_ctrl_type'(w_data_q[4:0]);
                OFS_IRQ_MASK: irq_mask_q <= rsli_evt_type'(w_data_q[1:0]);
                default: ;
            endcase
        end
    end

    // a new event beats a write-one-to-clear in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_status_q <= IRQ_RESET;
            irq <= 1'b0;
        end else begin
            if (do_write && w_lane0_q && waddr == OFS_IRQ_STATUS) begin
                irq_status_q <= (irq_status_q & ~rsli_evt_type'(w_data_q[1:0])) | evt;
            end else begin
                irq_status_q <= irq_status_q | evt;
            end
            irq <= |(irq_status_q & irq_mask_q);
        end
    end

    // =================================================================
    // read channel
    logic [31:0] rd_word;
    logic rd_err;
    logic [7:0] raddr;

    assign raddr = 8'(araddr);

    always_comb begin
        rd_word = 32'h0;
        rd_err = 1'b0;
        unique case (raddr)
            OFS_INPUT3_GAIN: rd_word = {21'h0, in3_gain_q};
            OFS_INPUT4_GAIN: rd_word = {21'h0, in4_gain_q};
            OFS_SPEED_REF_GAIN: rd_word = {21'h0, spd_gain_q};
            OFS_AOUT1_GAIN: rd_word = {21'h0, ao1_gain_q};
            OFS_AOUT2_GAIN: rd_word = {21'h0, ao2_gain_q};
            OFS_AOUT3_GAIN: rd_word = {21'h0, ao3_gain_q};
            OFS_ENC_REF_GAIN: rd_word = {21'h0, enc_gain_q};
            OFS_CONTROL: rd_word = {27'h0, ctrl_q};
            // live terminal levels plus trip and latched run commands
            OFS_INPUT_STATE: rd_word = {24'h0, run_reverse_cmd, run_forward_cmd,
                                        loop_loss_trip, pins_q};
            OFS_IRQ_STATUS: rd_word = {30'h0, irq_status_q};
            OFS_IRQ_MASK: rd_word = {30'h0, irq_mask_q};
            default: rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_word;
                rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end else if (!rvalid) begin
                arready <= 1'b1;
            end
        end
    end

    // =================================================================
    // reference path
    logic signed [10:0] analog_ref;
    logic signed [10:0] ref_sel;
    logic loop_low;
    logic permit_seen_q;

    // the 3.5 mA loss limit is only checked on offset ranges in current mode
    assign loop_low = ctrl_q.voltage_current_select && ctrl_q.current_range_select_high &&
                      reference_current_ua < LOOP_LOSS_UA;
    assign analog_ref = ctrl_q.voltage_current_select ?
        loop_to_ref(reference_current_ua, {ctrl_q.current_range_select_high,
                                           ctrl_q.current_range_select_low}) :
        speed_reference_reading;
    assign ref_sel = ctrl_q.reference_source_select ?
        scale_sat(encoder_reference, enc_gain_q) :
        scale_sat(16'(analog_ref), spd_gain_q);
    // falling edge only, so a permit that is low out of reset raises no event
    assign evt = '{permit_lost: !pins_q.run_permit && permit_seen_q,
                   loop_loss: loop_low && !loop_loss_trip};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            general_input_3_scaled <= '0;
            general_input_4_scaled <= '0;
            pre_ramp_reference <= '0;
            analog_output1 <= '0;
            analog_output2 <= '0;
            analog_output3 <= '0;
            loop_loss_trip <= 1'b0;
            permit_seen_q <= 1'b0;
        end else begin
            general_input_3_scaled <= scale_sat(16'(general_input_3), in3_gain_q);
            general_input_4_scaled <= scale_sat(16'(general_input_4), in4_gain_q);
            pre_ramp_reference <= pins_q.run_permit ? ref_sel : 11'sh0;
            analog_output1 <= scale_sat(16'(analog_output1_source), ao1_gain_q);
            analog_output2 <= scale_sat(16'(analog_output2_source), ao2_gain_q);
            analog_output3 <= scale_sat(16'(analog_output3_source), ao3_gain_q);
            loop_loss_trip <= loop_low;
            permit_seen_q <= pins_q.run_permit;
        end
    end

    // =================================================================
    // logic input commands
    logic normal_mode;

    assign normal_mode = !ctrl_q.normal_logic_disable;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            drive_stop <= 1'b0;
            ramp_freeze <= 1'b0;
            inch_reverse_cmd <= 1'b0;
            inch_forward_cmd <= 1'b0;
            run_reverse_cmd <= 1'b0;
            run_forward_cmd <= 1'b0;
        end else begin
            drive_stop <= !pins_q.run_permit && !ramp_hold_active;
            ramp_freeze <= !pins_q.run_permit && ramp_hold_active;
            inch_reverse_cmd <= normal_mode && pins_q.inch_reverse;
            inch_forward_cmd <= normal_mode && pins_q.inch_forward;
            // a lost permit clears the latch even if the run input is held
            run_reverse_cmd <= pins_q.run_permit && normal_mode &&
                               (run_reverse_cmd || pins_q.run_reverse);
            run_forward_cmd <= pins_q.run_permit && normal_mode &&
                               (run_forward_cmd || pins_q.run_forward);
        end
    end

    // =================================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    permit_zero_a: assert property (!pins_q.run_permit |=> pre_ramp_reference == 11'sh0)
        else $error("reference not zero without run permit");
    gain_off_a: assert property (in3_gain_q == 11'h0 |=> general_input_3_scaled == 11'sh0)
        else $error("zero gain did not switch input off");
    unity_gain_a: assert property (in4_gain_q == GAIN_UNITY |=>
        general_input_4_scaled == $past(general_input_4))
        else $error("unity gain changed the input");
    output_off_a: assert property (ao2_gain_q == 11'h0 |=> analog_output2 == 11'sh0)
        else $error("zero output gain did not disable output");
    saturate_range_a: assert property (pre_ramp_reference <= FULL_SCALE &&
        pre_ramp_reference >= -FULL_SCALE && analog_output1 <= FULL_SCALE)
        else $error("scaled result beyond full scale");
    encoder_route_a: assert property (ctrl_q.reference_source_select && pins_q.run_permit |=>
        pre_ramp_reference == $past(scale_sat(encoder_reference, enc_gain_q)))
        else $error("encoder reference not routed");
    loop_trip_a: assert property (loop_low ##1 loop_low |-> loop_loss_trip)
        else $error("current loop loss did not trip");
    stop_hold_a: assert property (!pins_q.run_permit && !ramp_hold_active |=>
        drive_stop && !ramp_freeze)
        else $error("permit loss did not stop drive");
    latch_keep_a: assert property (run_forward_cmd && pins_q.run_permit && normal_mode |=>
        run_forward_cmd)
        else $error("run forward latch dropped");
    permit_clear_a: assert property (!pins_q.run_permit |=>
        !run_forward_cmd && !run_reverse_cmd)
        else $error("run latch survived permit loss");
    inch_gate_a: assert property (!normal_mode |=> !inch_forward_cmd && !inch_reverse_cmd)
        else $error("inch command with normal logic disabled");

    run_latched_c: cover property (pins_q.run_forward ##1 !pins_q.run_forward && run_forward_cmd);
    loop_lost_c: cover property (loop_loss_trip && irq);
    encoder_ref_c: cover property (ctrl_q.reference_source_select && pre_ramp_reference != 11'sh0);

endmodule
